// ---- pmbpc_bench.sv ----
/*
 Self-checking bench for the power configuration interpreter.
 Assumes the master model drives commands; half-ms tick shortened to 4.
*/
`timescale 1ns/1ns
`default_nettype none
module pmbpc_bench;
    import pmbpc_pkg::*;
    localparam int TICK = 4;
    logic sys_clk, rstn, cmd_valid, rsp_valid, on_off_pin, nv_store;
    logic fault_clear, comm_fault, out_enable, soft_start, v;
    logic [15:0] rsp_data, vout_adc, factory_offset, vout_target, r;
    pmbpc_cmd_t cmd;
    pmbpc_nv_t nv_defaults, nv_image;
    int fails, tests_run;
    ////////////////////////////////////////////////////////////////
    // Design and far-side master
    pmbpc_core #(.HALF_MS_CYC(TICK)) DUT (.sys_clk(sys_clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .on_off_pin(on_off_pin), .vout_adc(vout_adc), .factory_offset(factory_offset),
        .nv_defaults(nv_defaults), .nv_store(nv_store), .nv_image(nv_image),
        .fault_clear(fault_clear), .comm_fault(comm_fault), .out_enable(out_enable),
        .soft_start(soft_start), .vout_target(vout_target));
    pmbpc_master master (.sys_clk(sys_clk), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd(cmd));
    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    // Bus helpers
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        master.xfer(1'b0, c, 16'h0000, v, d);
        check({15'h0, v}, 16'h0001);
    endtask : rd
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        master.xfer(1'b1, c, d, v, r);
        check({15'h0, v}, 16'h0000);
    endtask : wr
    task automatic clr();
        fault_clear <= 1'b1;
        @(posedge sys_clk);
        fault_clear <= 1'b0;
    endtask : clr
    // Bounded wait on out_enable (sel 0) or soft_start (sel 1)
    task automatic wait_lvl(input logic sel, input logic lvl, input int lim, output int n);
        for (n = 0; n < lim && (sel ? soft_start : out_enable) !== lvl; n++) begin
            @(posedge sys_clk);
        end
        if ((sel ? soft_start : out_enable) !== lvl) begin
            fails++;
            $display("MISMATCH t=%0t wait limit", $time);
            final_report();
        end
    endtask : wait_lvl
    ////////////////////////////////////////////////////////////////
    // Values after reset and default load
    task automatic t_reset();
        rd(CMD_EXP_MODE, r);
        check(r & 16'h00FF, {8'h00, EXP_MODE_VAL});
        rd(CMD_IN_ON, r);
        check(r, nv_defaults.in_on);
        rd(CMD_ON_OFF_CFG, r);
        check(r & 16'h001F, {11'h0, CFG_RESET});
        rd(CMD_OPERATION, r);
        check(r & 16'h00FF, {8'h00, OP_RESET});
        check(vout_target, nv_defaults.vout);
        check({15'h0, out_enable}, 16'h0000);
        check({15'h0, comm_fault}, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    // Range limits, formats and read-only codes
    task automatic t_ranges();
        logic [24:0] tb [0:21];
        logic [15:0] last;
        tb = '{{CMD_IN_OFF, 16'hE900, 1'b1}, {CMD_IN_OFF, 16'hE8FF, 1'b0},
            {CMD_IN_ON, 16'hE970, 1'b1}, {CMD_IN_ON, 16'hE971, 1'b0},
            {CMD_IN_ON, 16'h0170, 1'b0}, {CMD_ON_DELAY, 16'hF814, 1'b1},
            {CMD_ON_DELAY, 16'hF813, 1'b0}, {CMD_ON_DELAY, 16'hFBE9, 1'b0},
            {CMD_ON_DELAY, 16'hFC14, 1'b0}, {CMD_RISE_TIME, 16'hFBE8, 1'b1},
            {CMD_RISE_TIME, 16'hF81D, 1'b0}, {CMD_RISE_TIME, 16'hF81E, 1'b1},
            {CMD_VOUT_SET, 16'h819A, 1'b1}, {CMD_VOUT_SET, 16'h8199, 1'b0},
            {CMD_VOUT_SET, 16'hD334, 1'b0}, {CMD_VOUT_SET, 16'hD333, 1'b1},
            {CMD_MARGIN_HI, 16'hD000, 1'b1}, {CMD_MARGIN_LO, 16'h9000, 1'b1},
            {CMD_MARGIN_LO, 16'h8199, 1'b0}, {CMD_EXP_MODE, 16'h0000, 1'b0},
            {CMD_OUT_READ, 16'h0000, 1'b0}, {8'h7F, 16'h0000, 1'b0}};
        last = 16'h0000;
        for (int i = 0; i < 22; i++) begin
            clr();
            wr(tb[i][24:17], tb[i][16:1]);
            check({15'h0, comm_fault}, {15'h0, ~tb[i][0]});
            if (tb[i][0]) begin
                last = tb[i][16:1];
            end
            if (!(tb[i][24:17] inside {CMD_EXP_MODE, CMD_OUT_READ, 8'h7F})) begin
                rd(tb[i][24:17], r);
                check(r, last);
            end
        end
        $display("test ranges done");
    endtask : t_ranges
    // Margin selection through the control byte
    task automatic t_margin();
        clr();
        wr(CMD_OPERATION, 16'h00A8);
        @(posedge sys_clk);
        check(vout_target, 16'hD000);
        wr(CMD_OPERATION, 16'h0098);
        @(posedge sys_clk);
        check(vout_target, 16'h9000);
        wr(CMD_OPERATION, 16'h0084);
        @(posedge sys_clk);
        check(vout_target, 16'hD333);
        wr(CMD_OPERATION, 16'h0090);
        @(posedge sys_clk);
        check({15'h0, comm_fault}, 16'h0001);
        check(vout_target, 16'hD333);
        $display("test margin done");
    endtask : t_margin
    // Start-up timing and on/off gating
    task automatic t_power();
        int n;
        on_off_pin <= 1'b1;
        wait_lvl(1'b0, 1'b1, 400, n);
        check({15'h0, n >= 80 && n <= 87}, 16'h0001);
        check({15'h0, soft_start}, 16'h0001);
        wait_lvl(1'b1, 1'b0, 300, n);
        check({15'h0, n >= 116 && n <= 124}, 16'h0001);
        wr(CMD_OPERATION, 16'h0000);
        wait_lvl(1'b0, 1'b0, 3, n);
        check({15'h0, out_enable}, 16'h0000);
        wr(CMD_ON_OFF_CFG, 16'h0000);
        rd(CMD_ON_OFF_CFG, r);
        check(r & 16'h001F, 16'h0017);
        wait_lvl(1'b0, 1'b1, 300, n);
        check({15'h0, out_enable}, 16'h0001);
        on_off_pin <= 1'b0;
        wait_lvl(1'b0, 1'b0, 6, n);
        check({15'h0, out_enable}, 16'h0000);
        wr(CMD_ON_OFF_CFG, 16'h0008);
        on_off_pin <= 1'b1;
        repeat (150) @(posedge sys_clk);
        check({15'h0, out_enable}, 16'h0000);
        wr(CMD_OPERATION, 16'h0080);
        wait_lvl(1'b0, 1'b1, 300, n);
        check({15'h0, out_enable}, 16'h0001);
        $display("test power done");
    endtask : t_power
    // Corrected readback, clamping and the factory offset
    task automatic t_readback();
        logic [15:0] adc [0:2];
        logic [15:0] ofs [0:2];
        logic [15:0] exp [0:2];
        adc = '{16'hC000, 16'hFFF0, 16'h0010};
        ofs = '{16'hFFF0, 16'h0020, 16'hFFE0};
        exp = '{16'hBFF0, 16'hFFFF, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            vout_adc <= adc[i];
            factory_offset <= ofs[i];
            rd(CMD_OUT_READ, r);
            check(r, exp[i]);
            rd(CMD_RD_OFFSET, r);
            check(r, ofs[i]);
        end
        clr();
        rd(8'h7F, r);
        check(r, 16'h0000);
        check({15'h0, comm_fault}, 16'h0001);
        $display("test readback done");
    endtask : t_readback
    // Settings reach storage only on the store command
    task automatic t_store();
        wr(CMD_MARGIN_LO, 16'hB000);
        check({15'h0, nv_store}, 16'h0000);
        wr(CMD_STORE_ALL, 16'h0000);
        check({15'h0, nv_store}, 16'h0001);
        check(nv_image.margin_lo, 16'hB000);
        check(nv_image.vout, 16'hD333);
        check(nv_image.in_on, 16'hE970);
        check(nv_image.rise_time, 16'hF81E);
        $display("test store done");
    endtask : t_store
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fails = 0;
        tests_run = 0;
        rstn = 1'b0;
        on_off_pin = 1'b0;
        fault_clear = 1'b0;
        vout_adc = 16'hC000;
        factory_offset = 16'h0000;
        nv_defaults = '{16'hE940, 16'hE920, 16'hF828, 16'hF832, 16'hC800, 16'hD000, 16'h9000};
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_reset();
        t_ranges();
        t_margin();
        t_power();
        t_readback();
        t_store();
        final_report();
    end
endmodule : pmbpc_bench
`default_nettype wire

// ---- pmbpc_core.sv ----
/*
 Command interpreter for output on/off, lockout thresholds,
 soft start timing, setpoint, margins and voltage readback.
 Assumes commands arrive decoded on sys_clk; the on/off pin is
 asynchronous; the converter and storage sit outside.
*/
`timescale 1ns/1ns
`default_nettype none
module pmbpc_core #(
    parameter int HALF_MS_CYC = pmbpc_pkg::HALF_MS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire pmbpc_pkg::pmbpc_cmd_t cmd,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    input wire logic on_off_pin,
    input wire logic [15:0] vout_adc,
    input wire logic [15:0] factory_offset,
    input wire pmbpc_pkg::pmbpc_nv_t nv_defaults,
    output logic nv_store,
    output pmbpc_pkg::pmbpc_nv_t nv_image,
    input wire logic fault_clear,
    output logic comm_fault,
    output logic out_enable,
    output logic soft_start,
    output logic [15:0] vout_target
);
    import pmbpc_pkg::*;

    ////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] op_ctl;
    logic [4:0] cfg;
    pmbpc_nv_t set;
    logic load_pend;
    logic pin_m;
    logic pin_s;
    logic legal;
    logic wr_cmd;
    logic rd_cmd;
    logic pin_ok;
    logic run_ok;
    logic [15:0] vout_rd;
    logic [16:0] rd_sum;
    logic [13:0] div_cnt;
    logic tick;
    logic [10:0] step_cnt;
    pmbpc_pwr_t state;
    pmbpc_pwr_t next_state;
    logic rd_known;

    // Assertion clock and reset for the whole module
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Tick counter must fit and be non-zero
    generate
        if (HALF_MS_CYC < 1 || HALF_MS_CYC > 16384) begin : g_chk
            $error("HALF_MS_CYC out of range");
        end
    endgenerate

    // Linear word check: exponent field and mantissa window
    function automatic logic lin_ok(input logic [15:0] w,
        input logic [4:0] e, input logic [10:0] lo,
        input logic [10:0] hi);
        lin_ok = (w[15:11] == e) && (w[10:0] >= lo) &&
            (w[10:0] <= hi);
    endfunction : lin_ok

    ////////////////////////////////////////////////////////////
    // Command decode and range check
    assign wr_cmd = cmd_valid && cmd.write;
    assign rd_cmd = cmd_valid && !cmd.write;

    // Commands are whole transactions, so bus rate is irrelevant
    always_comb begin
        case (cmd.code)
            CMD_OPERATION: legal = (cmd.data[5:4] == 2'b00) ||
                (cmd.data[5:2] == MRG_LOW) ||
                (cmd.data[5:2] == MRG_HIGH);
            CMD_ON_OFF_CFG: legal = 1'b1;
            CMD_STORE_ALL: legal = 1'b1;
            CMD_IN_ON,
            CMD_IN_OFF: legal = lin_ok(cmd.data, EXP_VIN,
                VIN_MIN, VIN_MAX);
            CMD_ON_DELAY: legal = lin_ok(cmd.data, EXP_TIME,
                DELAY_MIN, TIME_MAX);
            CMD_RISE_TIME: legal = lin_ok(cmd.data, EXP_TIME,
                RISE_MIN, TIME_MAX);
            CMD_VOUT_SET,
            CMD_MARGIN_HI,
            CMD_MARGIN_LO: legal = (cmd.data >= VOUT_MIN) &&
                (cmd.data <= VOUT_MAX);
            default: legal = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////
    // Control bytes; whole operation byte writable, of the on/off config only the command-response option
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            op_ctl <= OP_RESET;
            cfg <= CFG_RESET;
        end else if (wr_cmd && legal) begin
            if (cmd.code == CMD_OPERATION) begin
                op_ctl <= cmd.data[7:0];
            end
            if (cmd.code == CMD_ON_OFF_CFG) begin
                cfg[CFG_CMD] <= cmd.data[CFG_CMD];
            end
        end
    end

    // Volatile settings; stored defaults load once after reset
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            load_pend <= 1'b1;
            set <= {IN_ON_RESET, IN_OFF_RESET, DELAY_RESET,
                RISE_RESET, VOUT_RESET, VOUT_RESET, VOUT_RESET};
        end else if (load_pend) begin
            load_pend <= 1'b0;
            set <= nv_defaults;
        end else if (wr_cmd && legal) begin
            case (cmd.code)
                CMD_IN_ON: set.in_on <= cmd.data;
                CMD_IN_OFF: set.in_off <= cmd.data;
                CMD_ON_DELAY: set.on_delay <= cmd.data;
                CMD_RISE_TIME: set.rise_time <= cmd.data;
                CMD_VOUT_SET: set.vout <= cmd.data;
                CMD_MARGIN_HI: set.margin_hi <= cmd.data;
                CMD_MARGIN_LO: set.margin_lo <= cmd.data;
                default: set <= set;
            endcase
        end
    end

    // Snapshot to storage only on the store command
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            nv_store <= 1'b0;
            nv_image <= '0;
        end else begin
            nv_store <= wr_cmd && (cmd.code == CMD_STORE_ALL);
            if (wr_cmd && (cmd.code == CMD_STORE_ALL)) begin
                nv_image <= set;
            end
        end
    end

    // Codes that answer a read; any other read returns zero and sets the fault
    assign rd_known = cmd.code inside {CMD_OPERATION, CMD_ON_OFF_CFG,
        CMD_EXP_MODE, CMD_IN_ON, CMD_IN_OFF, CMD_ON_DELAY, CMD_RISE_TIME,
        CMD_VOUT_SET, CMD_MARGIN_HI, CMD_MARGIN_LO, CMD_OUT_READ,
        CMD_RD_OFFSET};

    // Sticky fault; a new fault beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            comm_fault <= 1'b0;
        end else if (cmd_valid && (cmd.write ? !legal : !rd_known)) begin
            comm_fault <= 1'b1;
        end else if (fault_clear) begin
            comm_fault <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////
    // Readback with factory offset, clamped to unsigned range
    assign rd_sum = {1'b0, vout_adc} +
        {factory_offset[15], factory_offset};

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            vout_rd <= 16'h0000;
        end else if (factory_offset[15] && rd_sum[16]) begin // Below zero
            vout_rd <= 16'h0000;
        end else if (!factory_offset[15] && rd_sum[16]) begin
            vout_rd <= 16'hFFFF;
        end else begin
            vout_rd <= rd_sum[15:0];
        end
    end

    // Read answers, one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= rd_cmd;
            case (cmd.code)
                CMD_OPERATION: rsp_data <= {8'h00, op_ctl};
                CMD_ON_OFF_CFG: rsp_data <= {11'h000, cfg};
                CMD_EXP_MODE: rsp_data <= {8'h00, EXP_MODE_VAL};
                CMD_IN_ON: rsp_data <= set.in_on;
                CMD_IN_OFF: rsp_data <= set.in_off;
                CMD_ON_DELAY: rsp_data <= set.on_delay;
                CMD_RISE_TIME: rsp_data <= set.rise_time;
                CMD_VOUT_SET: rsp_data <= set.vout;
                CMD_MARGIN_HI: rsp_data <= set.margin_hi;
                CMD_MARGIN_LO: rsp_data <= set.margin_lo;
                CMD_OUT_READ: rsp_data <= vout_rd;
                CMD_RD_OFFSET: rsp_data <= factory_offset;
                default: rsp_data <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // On/off pin synchroniser
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pin_m <= 1'b0;
            pin_s <= 1'b0;
        end else begin
            pin_m <= on_off_pin;
            pin_s <= pin_m;
        end
    end

    // Start permission from pin, options and enable bit
    assign pin_ok = !(cfg[CFG_PIN_REQUIRED] || cfg[CFG_POWER_UP_GATE]) ||
        (pin_s == cfg[CFG_PIN_POLARITY]);
    assign run_ok = pin_ok &&
        (!cfg[CFG_CMD] || op_ctl[OP_ON]);

    // Half-millisecond tick, held in phase while off
    always_ff @(posedge sys_clk) begin
        if (!rstn || state == PS_OFF ||
            div_cnt == 14'(HALF_MS_CYC - 1)) begin
            div_cnt <= 14'h0000;
        end else begin
            div_cnt <= div_cnt + 14'h0001;
        end
    end
    assign tick = (state != PS_OFF) &&
        (div_cnt == 14'(HALF_MS_CYC - 1));

    // Delay then rise sequencing
    always_comb begin
        next_state = state;
        case (state)
            PS_OFF: if (run_ok) next_state = PS_DELAY;
            PS_DELAY: begin
                if (!run_ok) begin
                    next_state = PS_OFF;
                end else if (tick && step_cnt + 11'h001 >=
                    set.on_delay[10:0]) begin
                    next_state = PS_RISE;
                end
            end
            PS_RISE: begin
                if (!run_ok) begin
                    next_state = PS_OFF;
                end else if (tick && step_cnt + 11'h001 >=
                    set.rise_time[10:0]) begin
                    next_state = PS_ON;
                end
            end
            PS_ON: if (!run_ok) next_state = PS_OFF;
            default: next_state = PS_OFF;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= PS_OFF;
            step_cnt <= 11'h000;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                step_cnt <= 11'h000;
            end else if (tick) begin
                step_cnt <= step_cnt + 11'h001;
            end
        end
    end

    // Output drive and level selection
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            out_enable <= 1'b0;
            soft_start <= 1'b0;
            vout_target <= VOUT_RESET;
        end else begin
            out_enable <= next_state == PS_RISE ||
                next_state == PS_ON;
            soft_start <= next_state == PS_RISE;
            case (op_ctl[5:2])
                MRG_LOW: vout_target <= set.margin_lo;
                MRG_HIGH: vout_target <= set.margin_hi;
                default: vout_target <= set.vout;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Checks
    sequence bad_wr_s;
        wr_cmd && !legal && !load_pend;
    endsequence
    sequence store_s;
        wr_cmd && cmd.code == CMD_STORE_ALL && !load_pend;
    endsequence

    bad_sets_fault_a: assert property (
        bad_wr_s |=> comm_fault)
        else $error("rejected write did not flag fault");
    bad_keeps_set_a: assert property (
        bad_wr_s |=> $stable(set))
        else $error("rejected write changed a setting");
    store_snap_a: assert property (
        store_s |=> nv_store && nv_image == $past(set))
        else $error("store did not capture settings");
    no_store_a: assert property (
        !(wr_cmd && cmd.code == CMD_STORE_ALL) |=> !nv_store)
        else $error("storage written without store command");
    mode_read_a: assert property (
        rd_cmd && cmd.code == CMD_EXP_MODE |=>
        rsp_valid && rsp_data == 16'h0014)
        else $error("mode query wrong");
    pin_block_a: assert property (
        cfg[CFG_PIN_REQUIRED] && pin_s != cfg[CFG_PIN_POLARITY] |=> !out_enable)
        else $error("started without pin");
    op_off_a: assert property (
        cfg[CFG_CMD] && !op_ctl[OP_ON] |=> !out_enable)
        else $error("output on while commanded off");
    delay_hold_a: assert property (
        state == PS_OFF ##1 state == PS_DELAY |->
        !out_enable [*2])
        else $error("output rose before delay");
    margin_sel_a: assert property (
        op_ctl[5:2] == MRG_HIGH |=> vout_target == $past(set.margin_hi))
        else $error("margin high not selected");
    readback_a: assert property (
        rd_cmd && cmd.code == CMD_OUT_READ |=> rsp_data == $past(vout_rd))
        else $error("readback value wrong");
endmodule : pmbpc_core
`default_nettype wire

// ---- pmbpc_master.sv ----
/*
 Command-port master model for the power configuration interpreter.
 Assumes the caller runs in step with sys_clk; one command per call.
*/
`timescale 1ns/1ns
`default_nettype none
module pmbpc_master (
    input wire logic sys_clk,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    output logic cmd_valid,
    output pmbpc_pkg::pmbpc_cmd_t cmd
);
    import pmbpc_pkg::*;
    ////////////////////////////////////////////////////////////////
    // Port idle from time zero
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // One command, answer taken at the edge after the taking edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic v, output logic [15:0] r);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd <= '{write: w, code: c, data: d};
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        // Released fields never keep the last value
        cmd <= ~cmd;
        @(posedge sys_clk);
        v = rsp_valid;
        r = rsp_data;
    endtask : xfer
endmodule : pmbpc_master
`default_nettype wire

// ---- pmbpc_pkg.sv ----
/*
 Constants, command codes and carrier types of the power
 configuration command interpreter.
 Assumes a link layer that hands over whole decoded commands.
*/
package pmbpc_pkg;
    // Command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
    localparam logic [7:0] CMD_STORE_ALL = 8'h11;
    localparam logic [7:0] CMD_EXP_MODE = 8'h20;
    localparam logic [7:0] CMD_VOUT_SET = 8'h21;
    localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
    localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
    localparam logic [7:0] CMD_IN_ON = 8'h35;
    localparam logic [7:0] CMD_IN_OFF = 8'h36;
    localparam logic [7:0] CMD_ON_DELAY = 8'h60;
    localparam logic [7:0] CMD_RISE_TIME = 8'h61;
    localparam logic [7:0] CMD_OUT_READ = 8'h8B;
    localparam logic [7:0] CMD_RD_OFFSET = 8'hD0;
    // Exponent fields and the mode byte
    localparam logic [4:0] EXP_VIN = 5'h1D;
    localparam logic [4:0] EXP_TIME = 5'h1F;
    localparam logic [7:0] EXP_MODE_VAL = 8'h14;
    // Mantissa limits, then whole-word output voltage limits
    localparam logic [10:0] VIN_MIN = 11'h100;
    localparam logic [10:0] VIN_MAX = 11'h170;
    localparam logic [10:0] DELAY_MIN = 11'h014;
    localparam logic [10:0] RISE_MIN = 11'h01E;
    localparam logic [10:0] TIME_MAX = 11'h3E8;
    localparam logic [15:0] VOUT_MIN = 16'h819A;
    localparam logic [15:0] VOUT_MAX = 16'hD333;
    // Bit positions and margin field codes
    localparam int OP_ON = 7;
    localparam int CFG_POWER_UP_GATE = 4;
    localparam int CFG_CMD = 3;
    localparam int CFG_PIN_REQUIRED = 2;
    localparam int CFG_PIN_POLARITY = 1;
    localparam logic [3:0] MRG_LOW = 4'h6;
    localparam logic [3:0] MRG_HIGH = 4'hA;
    // Values after reset
    localparam logic [7:0] OP_RESET = 8'h80;
    localparam logic [4:0] CFG_RESET = 5'h1F;
    localparam logic [15:0] IN_ON_RESET = 16'hE940;
    localparam logic [15:0] IN_OFF_RESET = 16'hE920;
    localparam logic [15:0] DELAY_RESET = 16'hF814;
    localparam logic [15:0] RISE_RESET = 16'hF81E;
    localparam logic [15:0] VOUT_RESET = 16'hC000;
    // Timing: half-millisecond tick at 25 MHz
    localparam int CLK_PERIOD_NS = 40;
    localparam int HALF_MS_NS = 500000;
    localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;

    // One command from the link layer
    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } pmbpc_cmd_t;

    // Settings kept in non-volatile storage
    typedef struct packed {
        logic [15:0] in_on;
        logic [15:0] in_off;
        logic [15:0] on_delay;
        logic [15:0] rise_time;
        logic [15:0] vout;
        logic [15:0] margin_hi;
        logic [15:0] margin_lo;
    } pmbpc_nv_t;

    typedef enum logic [3:0] {
        PS_OFF = 4'h1,
        PS_DELAY = 4'h2,
        PS_RISE = 4'h4,
        PS_ON = 4'h8
    } pmbpc_pwr_t;
endpackage : pmbpc_pkg
